// file: hw/exec_pkg.sv
// constants, types and carriers for the branch and misc executor
// assumes one core clock and a byte-wide memory with one-cycle reads
package exec_pkg;
  // ==========================================================
  // register map (byte addresses on the AHB-Lite slave)
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_STATUS = 8'h04;
  localparam logic [7:0] OFF_ACC = 8'h08;
  localparam logic [7:0] OFF_TMP = 8'h0C;
  localparam logic [7:0] OFF_IX = 8'h10;
  localparam logic [7:0] OFF_EP = 8'h14;
  localparam logic [7:0] OFF_SP = 8'h18;
  localparam logic [7:0] OFF_PC = 8'h1C;
  localparam logic [7:0] OFF_PS = 8'h20;
  localparam logic [7:0] OFF_OPC = 8'h24;
  localparam logic [2:0] GPR_PAGE = 3'h2;
  localparam int CTRL_STEP = 0;
  localparam int CTRL_RUN = 1;
  localparam int ST_BUSY = 0;
  localparam int ST_RSVD = 1;
  // ==========================================================
  // condition code bit positions
  localparam int F_C = 0;
  localparam int F_V = 1;
  localparam int F_Z = 2;
  localparam int F_N = 3;
  localparam int F_I = 4;
  // ==========================================================
  // reset values and fixed addressing
  localparam logic [15:0] PC_RST = 16'h0000;
  localparam logic [15:0] SP_RST = 16'h0000;
  localparam logic [7:0] CCR_RST = 8'h00;
  localparam logic [7:0] DIR_PAGE = 8'h00;
  localparam logic [15:0] STK_WORD = 16'h0002;
  // ==========================================================
  // least cycle counts per instruction form
  localparam logic [3:0] CYC_CTL = 4'h1;
  localparam logic [3:0] CYC_TL = 4'h2;
  localparam logic [3:0] CYC_IMM = 4'h2;
  localparam logic [3:0] CYC_MEM = 4'h3;
  localparam logic [3:0] CYC_IXO = 4'h4;
  localparam logic [3:0] CYC_CMP5 = 4'h5;
  localparam logic [3:0] CYC_CMP4 = 4'h4;
  localparam logic [3:0] CYC_SPSTEP = 4'h3;
  localparam logic [3:0] CYC_BREL = 4'h3;
  localparam logic [3:0] CYC_BBIT = 4'h5;
  localparam logic [3:0] CYC_JMPA = 4'h2;
  localparam logic [3:0] CYC_JMPX = 4'h3;
  localparam logic [3:0] CYC_CALL = 4'h6;
  localparam logic [3:0] CYC_XCHPC = 4'h3;
  localparam logic [3:0] CYC_RET = 4'h4;
  localparam logic [3:0] CYC_INTERRUPT_RETURN = 4'h6;
  localparam logic [3:0] CYC_STACK = 4'h4;
  // ==========================================================
  // types
  typedef enum logic [4:0] {
    K_NOP, K_AND, K_OR, K_CMP, K_SPSTEP, K_BCOND, K_BBIT, K_JMPA,
    K_JMPX, K_VECTOR_CALL, K_CALL, K_XCHPC, K_RET, K_INTERRUPT_RETURN, K_PUSH, K_POP,
    K_CCLR, K_CSET, K_IDIS, K_IEN, K_RSVD
  } kind_t;
  typedef enum logic [2:0] {
    A_NONE, A_DIR, A_IX, A_EP, A_STK, A_VEC
  } asrc_t;
  typedef struct packed {
    kind_t kind;
    asrc_t asrc;
    logic [1:0] len;
    logic [2:0] nrd;
    logic [1:0] nwr;
    logic [3:0] cyc;
  } dec_t;
  typedef enum logic [2:0] {
    S_IDLE, S_FETCH, S_DEC, S_OPND, S_ADDR, S_RD, S_WR, S_EXEC
  } state_t;
  typedef struct packed {
    logic rd;
    logic wr;
    logic [15:0] addr;
    logic [7:0] wdata;
  } mem_req_t;
  typedef struct packed {
    state_t st;
    logic run;
    logic rsvd;
    logic [7:0] opc;
    dec_t d;
    logic [1:0][7:0] ops;
    logic [3:0][7:0] bufb;
    logic [2:0] k;
    logic [3:0] cnt;
    logic [15:0] a;
    logic [15:0] t;
    logic [15:0] ix;
    logic [15:0] ep;
    logic [15:0] sp;
    logic [15:0] pc;
    logic [7:0] ccr;
    logic [4:0] rp;
    logic [7:0][7:0] gpr;
    logic [31:0] hrdata;
    logic wpend;
    logic wmap;
    logic [7:0] waddr;
  } core_t;
endpackage

// file: hw/branch_cond.sv
// condition evaluator for the eight relative branches
// assumes sel_in is the low three opcode bits of an F8..FF branch
`timescale 1ns/1ps
module branch_cond (
  input wire logic [2:0] sel_in,
  input wire logic [7:0] ccr_in,
  output logic take_out
);
  import exec_pkg::*;
  logic cond;
  always_comb begin
    unique case (sel_in[2:1])
      2'b00: cond = ccr_in[F_C];
      2'b01: cond = ccr_in[F_N];
      2'b10: cond = ccr_in[F_Z];
      2'b11: cond = ccr_in[F_V] ^ ccr_in[F_N];
    endcase
    take_out = sel_in[0] ? cond : ~cond;
  end
endmodule // branch_cond

// file: hw/cpu_logic_branch_misc_exec.sv
// executor for logic, compare, branch, call, stack and flag instructions
// assumes a byte memory answering a read in the cycle after the request
// and an AHB-Lite master doing single word transfers
//
// Behaviour
// - AND forms: acc low byte ANDed, NZ set, V cleared
// - OR with general register, opcodes 78-7F
// - OR with temp low byte, opcode 72
// - OR with index plus offset operand, 76
// - AND through extra pointer, opcode 67
// - memory minus immediate compare sets NZVC
// - branch on zero set or clear
// - signed less and greater-equal use V xor N
// - bit-test branches on direct byte, Z only
// - jump from accumulator or absolute word
// - vector call and absolute subroutine call
// - swap program counter with accumulator
// - subroutine return leaves flags untouched
// - interrupt return restores saved flags
// - word push and pop of acc and index
// - nop, carry and interrupt enable controls
// - unmarked flags keep their previous value
// - operand bytes follow assembler operand order
//
// The placing of the registers and register access over AHB-Lite were chosen for this implementation.
`timescale 1ns/1ps
module cpu_logic_branch_misc_exec #(
  parameter logic [15:0] VEC_BASE = 16'hFFC0
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic hsel_in,
  input wire logic [31:0] haddr_in,
  input wire logic [1:0] htrans_in,
  input wire logic hwrite_in,
  input wire logic [2:0] hsize_in,
  input wire logic [31:0] hwdata_in,
  input wire logic hready_in,
  output logic [31:0] hrdata_out,
  output logic hreadyout_out,
  output logic hresp_out,
  output exec_pkg::mem_req_t mem_out,
  input wire logic [7:0] mem_rdata_in,
  output logic busy_out
);
  import exec_pkg::*;

  // ==========================================================
  // decoder
  function automatic dec_t decode(input logic [7:0] o);
    dec_t r;
    r = '{kind: K_RSVD, asrc: A_NONE, len: 2'd1, nrd: 3'd0,
          nwr: 2'd0, cyc: CYC_CTL};
    unique case (o[7:4])
      4'h6, 4'h7: begin
        r.kind = o[4] ? K_OR : K_AND;
        unique case (o[3:0])
          4'h2: r.cyc = CYC_TL;
          4'h4: begin
            r.len = 2'd2;
            r.cyc = CYC_IMM;
          end
          4'h5: begin
            r.len = 2'd2;
            r.asrc = A_DIR;
            r.nrd = 3'd1;
            r.cyc = CYC_MEM;
          end
          4'h6: begin
            r.len = 2'd2;
            r.asrc = A_IX;
            r.nrd = 3'd1;
            r.cyc = CYC_IXO;
          end
          4'h7: begin
            r.asrc = A_EP;
            r.nrd = 3'd1;
            r.cyc = CYC_MEM;
          end
          4'h8, 4'h9, 4'hA, 4'hB, 4'hC, 4'hD, 4'hE, 4'hF:
            r.cyc = CYC_MEM;
          default: r.kind = K_RSVD;
        endcase
      end
      4'h9: begin
        r.kind = K_CMP;
        unique case (o[3:0])
          4'h0: r.kind = K_IEN;
          4'h1: r.kind = K_CSET;
          4'h5: begin
            r.len = 2'd3;
            r.asrc = A_DIR;
            r.nrd = 3'd1;
            r.cyc = CYC_CMP5;
          end
          4'h6: begin
            r.len = 2'd3;
            r.asrc = A_IX;
            r.nrd = 3'd1;
            r.cyc = CYC_CMP5;
          end
          4'h7: begin
            r.len = 2'd2;
            r.asrc = A_EP;
            r.nrd = 3'd1;
            r.cyc = CYC_CMP4;
          end
          4'h8, 4'h9, 4'hA, 4'hB, 4'hC, 4'hD, 4'hE, 4'hF: begin
            r.len = 2'd2;
            r.cyc = CYC_CMP4;
          end
          default: r.kind = K_RSVD;
        endcase
      end
      4'h8: begin
        if (o[3:0] == 4'h0) r.kind = K_IDIS;
        if (o[3:0] == 4'h1) r.kind = K_CCLR;
      end
      4'h0: if (o[3:0] == 4'h0) r.kind = K_NOP;
      4'hC, 4'hD: if (o[3:0] == 4'h1) begin
        r.kind = K_SPSTEP;
        r.cyc = CYC_SPSTEP;
      end
      4'hF: begin
        if (o[3]) begin
          r.kind = K_BCOND;
          r.len = 2'd2;
          r.cyc = CYC_BREL;
        end else if (o[3:0] == 4'h4) begin
          r.kind = K_XCHPC;
          r.cyc = CYC_XCHPC;
        end
      end
      4'hB: begin
        r.kind = K_BBIT;
        r.len = 2'd3;
        r.asrc = A_DIR;
        r.nrd = 3'd1;
        r.cyc = CYC_BBIT;
      end
      4'hE: begin
        if (o[3]) begin
          r.kind = K_VECTOR_CALL;
          r.asrc = A_VEC;
          r.nrd = 3'd2;
          r.nwr = 2'd2;
          r.cyc = CYC_CALL;
        end else if (o[3:0] == 4'h0) begin
          r.kind = K_JMPA;
          r.cyc = CYC_JMPA;
        end
      end
      4'h2, 4'h3: begin
        if (o[3:0] == 4'h0) begin
          r.kind = o[4] ? K_INTERRUPT_RETURN : K_RET;
          r.asrc = A_STK;
          r.nrd = o[4] ? 3'd4 : 3'd2;
          r.cyc = o[4] ? CYC_INTERRUPT_RETURN : CYC_RET;
        end else if (o[3:0] == 4'h1) begin
          r.kind = o[4] ? K_CALL : K_JMPX;
          r.len = 2'd3;
          r.nwr = o[4] ? 2'd2 : 2'd0;
          r.cyc = o[4] ? CYC_CALL : CYC_JMPX;
        end
      end
      4'h4, 4'h5: if (o[3:1] == 3'h0) begin
        r.kind = o[4] ? K_POP : K_PUSH;
        r.asrc = o[4] ? A_STK : A_NONE;
        r.nrd = o[4] ? 3'd2 : 3'd0;
        r.nwr = o[4] ? 2'd0 : 2'd2;
        r.cyc = CYC_STACK;
      end
      default: r.kind = K_RSVD;
    endcase
    return r;
  endfunction

  // ==========================================================
  // state and datapath helpers
  core_t r_reg;
  core_t r_next;
  dec_t dnew;
  logic [15:0] nextpc;
  logic [15:0] rdbase;
  logic [15:0] wrbase;
  logic [15:0] word_push;
  logic [15:0] relpc;
  logic [7:0] srcb;
  logic [7:0] lres;
  logic [7:0] cx;
  logic [7:0] ci;
  logic [7:0] rel;
  logic [8:0] diff;
  logic take;
  logic bitv;
  logic aphase;
  logic step;

  assign dnew = decode(mem_rdata_in);
  assign nextpc = r_reg.pc + 16'(r_reg.d.len);
  assign wrbase = r_reg.sp - STK_WORD;
  // call pushes the address of the following instruction
  assign word_push = (r_reg.d.kind != K_PUSH) ? nextpc :
                 (r_reg.opc[0] ? r_reg.ix : r_reg.a);
  assign srcb = (r_reg.opc[3:0] == 4'h2) ? r_reg.t[7:0] :
                (r_reg.opc[3:0] == 4'h4) ? r_reg.ops[0] :
                r_reg.opc[3] ? r_reg.gpr[r_reg.opc[2:0]] : r_reg.bufb[0];
  assign lres = r_reg.opc[4] ? (r_reg.a[7:0] | srcb) :
                (r_reg.a[7:0] & srcb);
  // operand order: address byte first, immediate last
  assign cx = r_reg.opc[3] ? r_reg.gpr[r_reg.opc[2:0]] : r_reg.bufb[0];
  assign ci = (r_reg.opc[3] || r_reg.opc[3:0] == 4'h7) ?
              r_reg.ops[0] : r_reg.ops[1];
  assign diff = {1'b0, cx} - {1'b0, ci};
  assign bitv = r_reg.bufb[0][r_reg.opc[2:0]];
  assign rel = (r_reg.d.kind == K_BBIT) ? r_reg.ops[1] : r_reg.ops[0];
  assign relpc = nextpc + {{8{rel[7]}}, rel};
  assign aphase = hsel_in & htrans_in[1] & hready_in;
  assign step = r_reg.wpend & r_reg.wmap & (r_reg.waddr == OFF_CTRL) &
                hwdata_in[CTRL_STEP];

  always_comb begin
    unique case (r_reg.d.asrc)
      A_DIR: rdbase = {DIR_PAGE, r_reg.ops[0]};
      A_IX: rdbase = r_reg.ix + {{8{r_reg.ops[0][7]}}, r_reg.ops[0]};
      A_EP: rdbase = r_reg.ep;
      A_STK: rdbase = r_reg.sp;
      A_VEC: rdbase = VEC_BASE + {12'h000, r_reg.opc[2:0], 1'b0};
      default: rdbase = 16'h0000;
    endcase
  end

  branch_cond cond_u (
    .sel_in(r_reg.opc[2:0]),
    .ccr_in(r_reg.ccr),
    .take_out(take)
  );

  // ==========================================================
  // register read mux
  function automatic logic [31:0] rdmux(input core_t s,
                                        input logic [7:0] ad);
    logic [31:0] v;
    v = 32'h0000_0000;
    unique case (ad)
      OFF_CTRL: v[CTRL_RUN] = s.run;
      OFF_STATUS: begin
        v[ST_BUSY] = (s.st != S_IDLE);
        v[ST_RSVD] = s.rsvd;
      end
      OFF_ACC: v[15:0] = s.a;
      OFF_TMP: v[15:0] = s.t;
      OFF_IX: v[15:0] = s.ix;
      OFF_EP: v[15:0] = s.ep;
      OFF_SP: v[15:0] = s.sp;
      OFF_PC: v[15:0] = s.pc;
      OFF_PS: v[15:0] = {s.rp, 3'h0, s.ccr};
      OFF_OPC: v[7:0] = s.opc;
      default: if (ad[7:5] == GPR_PAGE && ad[1:0] == 2'h0)
        v[7:0] = s.gpr[ad[4:2]];
    endcase
    return v;
  endfunction

  // ==========================================================
  // memory request, decided by the current state only
  always_comb begin
    mem_out = '0;
    unique case (r_reg.st)
      S_FETCH: begin
        mem_out.rd = 1'b1;
        mem_out.addr = r_reg.pc;
      end
      // the second byte is read even for one-byte opcodes
      S_DEC: begin
        mem_out.rd = 1'b1;
        mem_out.addr = r_reg.pc + 16'h0001;
      end
      S_OPND: begin
        mem_out.rd = (r_reg.k == 3'd0) && (r_reg.d.len == 2'd3);
        mem_out.addr = r_reg.pc + 16'h0002;
      end
      S_ADDR: begin
        mem_out.rd = (r_reg.d.nrd != 3'd0);
        mem_out.addr = rdbase;
      end
      S_RD: begin
        mem_out.rd = ((r_reg.k + 3'd1) < r_reg.d.nrd);
        mem_out.addr = rdbase + 16'(r_reg.k + 3'd1);
      end
      S_WR: begin
        mem_out.wr = 1'b1;
        mem_out.addr = wrbase + 16'(r_reg.k);
        mem_out.wdata = r_reg.k[0] ? word_push[7:0] : word_push[15:8];
      end
      default: mem_out = '0;
    endcase
  end

  // ==========================================================
  // next state
  always_comb begin
    r_next = r_reg;
    r_next.wpend = aphase & hwrite_in;
    if (aphase) begin
      r_next.waddr = haddr_in[7:0];
      r_next.wmap = (haddr_in[31:8] == 24'h000000);
      r_next.hrdata = (haddr_in[31:8] == 24'h000000) ?
                      rdmux(r_reg, haddr_in[7:0]) : 32'h0000_0000;
    end
    if (r_reg.wpend && r_reg.wmap) begin
      if (r_reg.waddr == OFF_CTRL)
        r_next.run = hwdata_in[CTRL_RUN];
      if (r_reg.waddr == OFF_STATUS && hwdata_in[ST_RSVD])
        r_next.rsvd = 1'b0;
      // software may load the core registers only while idle
      if (r_reg.st == S_IDLE) begin
        unique case (r_reg.waddr)
          OFF_ACC: r_next.a = hwdata_in[15:0];
          OFF_TMP: r_next.t = hwdata_in[15:0];
          OFF_IX: r_next.ix = hwdata_in[15:0];
          OFF_EP: r_next.ep = hwdata_in[15:0];
          OFF_SP: r_next.sp = hwdata_in[15:0];
          OFF_PC: r_next.pc = hwdata_in[15:0];
          OFF_PS: begin
            r_next.rp = hwdata_in[15:11];
            r_next.ccr = hwdata_in[7:0];
          end
          default: if (r_reg.waddr[7:5] == GPR_PAGE &&
                       r_reg.waddr[1:0] == 2'h0)
            r_next.gpr[r_reg.waddr[4:2]] = hwdata_in[7:0];
        endcase
      end
    end
    if (r_reg.st != S_IDLE && r_reg.cnt != 4'hF)
      r_next.cnt = r_reg.cnt + 4'h1;
    unique case (r_reg.st)
      S_IDLE: if (r_reg.run || step) begin
        r_next.st = S_FETCH;
        r_next.cnt = 4'h1;
      end
      S_FETCH: r_next.st = S_DEC;
      S_DEC: begin
        r_next.opc = mem_rdata_in;
        r_next.d = dnew;
        r_next.k = 3'd0;
        r_next.st = (dnew.len != 2'd1) ? S_OPND : S_ADDR;
      end
      S_OPND: begin
        r_next.ops[r_reg.k[0]] = mem_rdata_in;
        if (r_reg.k == 3'd0 && r_reg.d.len == 2'd3) begin
          r_next.k = 3'd1;
        end else begin
          r_next.k = 3'd0;
          r_next.st = S_ADDR;
        end
      end
      S_ADDR: begin
        r_next.k = 3'd0;
        if (r_reg.d.nrd != 3'd0) r_next.st = S_RD;
        else if (r_reg.d.nwr != 2'd0) r_next.st = S_WR;
        else r_next.st = S_EXEC;
      end
      S_RD: begin
        r_next.bufb[r_reg.k[1:0]] = mem_rdata_in;
        if ((r_reg.k + 3'd1) < r_reg.d.nrd) begin
          r_next.k = r_reg.k + 3'd1;
        end else begin
          r_next.k = 3'd0;
          r_next.st = (r_reg.d.nwr != 2'd0) ? S_WR : S_EXEC;
        end
      end
      S_WR: begin
        r_next.k = r_reg.k + 3'd1;
        if (r_reg.k == 3'd1) r_next.st = S_EXEC;
      end
      S_EXEC: if (r_reg.cnt >= r_reg.d.cyc) begin
        r_next.pc = nextpc;
        r_next.st = r_reg.run ? S_FETCH : S_IDLE;
        r_next.cnt = 4'h1;
        // flags not named below keep their value
        unique case (r_reg.d.kind)
          K_AND, K_OR: begin
            r_next.a[7:0] = lres;
            r_next.ccr[F_N] = lres[7];
            r_next.ccr[F_Z] = (lres == 8'h00);
            r_next.ccr[F_V] = 1'b0;
          end
          K_CMP: begin
            r_next.ccr[F_N] = diff[7];
            r_next.ccr[F_Z] = (diff[7:0] == 8'h00);
            r_next.ccr[F_V] = (cx[7] ^ ci[7]) & (cx[7] ^ diff[7]);
            r_next.ccr[F_C] = diff[8];
          end
          K_SPSTEP: r_next.sp = r_reg.opc[4] ?
            r_reg.sp - 16'h0001 : r_reg.sp + 16'h0001;
          K_BCOND: if (take) r_next.pc = relpc;
          K_BBIT: begin
            r_next.ccr[F_Z] = ~bitv;
            if (r_reg.opc[3] == bitv) r_next.pc = relpc;
          end
          K_JMPA: r_next.pc = r_reg.a;
          K_JMPX: r_next.pc = {r_reg.ops[0], r_reg.ops[1]};
          K_CALL: begin
            r_next.pc = {r_reg.ops[0], r_reg.ops[1]};
            r_next.sp = wrbase;
          end
          K_VECTOR_CALL: begin
            r_next.pc = {r_reg.bufb[0], r_reg.bufb[1]};
            r_next.sp = wrbase;
          end
          K_XCHPC: begin
            r_next.pc = r_reg.a;
            r_next.a = r_reg.pc + 16'h0001;
          end
          K_RET: begin
            r_next.pc = {r_reg.bufb[0], r_reg.bufb[1]};
            r_next.sp = r_reg.sp + STK_WORD;
          end
          K_INTERRUPT_RETURN: begin
            r_next.pc = {r_reg.bufb[0], r_reg.bufb[1]};
            r_next.rp = r_reg.bufb[2][7:3];
            r_next.ccr = r_reg.bufb[3];
            r_next.sp = r_reg.sp + STK_WORD + STK_WORD;
          end
          K_PUSH: r_next.sp = wrbase;
          K_POP: begin
            if (r_reg.opc[0]) r_next.ix = {r_reg.bufb[0], r_reg.bufb[1]};
            else r_next.a = {r_reg.bufb[0], r_reg.bufb[1]};
            r_next.sp = r_reg.sp + STK_WORD;
          end
          K_CCLR: r_next.ccr[F_C] = 1'b0;
          K_CSET: r_next.ccr[F_C] = 1'b1;
          K_IDIS: r_next.ccr[F_I] = 1'b0;
          K_IEN: r_next.ccr[F_I] = 1'b1;
          K_RSVD: begin
            // set after the software clear, so a clash keeps the flag
            r_next.rsvd = 1'b1;
            r_next.run = 1'b0;
            r_next.st = S_IDLE;
          end
          default: r_next.pc = nextpc;
        endcase
      end
    endcase
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      r_reg <= '0;
      r_reg.st <= S_IDLE;
      r_reg.pc <= PC_RST;
      r_reg.sp <= SP_RST;
      r_reg.ccr <= CCR_RST;
    end else begin
      r_reg <= r_next;
    end
  end

  assign hrdata_out = r_reg.hrdata;
  assign hreadyout_out = 1'b1;
  assign hresp_out = 1'b0;
  assign busy_out = (r_reg.st != S_IDLE);
endmodule // cpu_logic_branch_misc_exec

// file: verif/exec_mem_model.sv
// byte memory model for the executor's memory port
// assumes one-cycle read latency and no back-pressure
`timescale 1ns/1ps
module exec_mem_model
  import exec_pkg::*;
(
  input wire logic clk_in,
  input wire exec_pkg::mem_req_t mem_in,
  output logic [7:0] rdata_out
);
  // ========================================
  // storage and read port
  logic [7:0] mem [0:65535];
  initial rdata_out = 8'hA5;
  always @(posedge clk_in) begin
    // the line toggles between reads so a stale byte never passes
    if (mem_in.rd)
      rdata_out <= mem[mem_in.addr];
    else
      rdata_out <= ~rdata_out;
    if (mem_in.wr)
      mem[mem_in.addr] <= mem_in.wdata;
  end
endmodule // exec_mem_model

// file: verif/exec_checks_properties.sv
// properties of the executor's memory port and bus answer
// assumes it is bound to the executor top module
`timescale 1ns/1ps
module exec_checks
  import exec_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic hreadyout_out,
  input wire logic hresp_out,
  input wire exec_pkg::mem_req_t mem_out,
  input wire logic busy_out
);
  // ========================================
  // memory port order and timing
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  chk_fetch_next: assert property ($rose(busy_out) |-> mem_out.rd
    ##1 (mem_out.rd && mem_out.addr == $past(mem_out.addr) + 16'h1))
    else $error("fetch not followed by next byte read");
  chk_busy_min: assert property ($rose(busy_out) |-> busy_out[*4])
    else $error("instruction shorter than four cycles");
  chk_busy_bound: assert property ($rose(busy_out) |-> ##[4:16] !busy_out)
    else $error("instruction did not finish");
  chk_idle_quiet: assert property (!busy_out |-> !mem_out.rd && !mem_out.wr)
    else $error("memory strobe while idle");
  chk_one_strobe: assert property (!(mem_out.rd && mem_out.wr))
    else $error("read and write together");
  chk_stack_pair: assert property ($rose(mem_out.wr) |=>
    (mem_out.wr && mem_out.addr == $past(mem_out.addr) + 16'h1) ##1 !mem_out.wr)
    else $error("stack word not two rising bytes");
  chk_start_no_wr: assert property ($rose(busy_out) |-> !mem_out.wr ##1 !mem_out.wr)
    else $error("write during fetch or decode");
  chk_bus_okay: assert property (hreadyout_out && !hresp_out)
    else $error("bus answer not ready okay");
endmodule // exec_checks

bind cpu_logic_branch_misc_exec exec_checks u_checks (
  .clk_in(clk_in),
  .rst_n_in(rst_n_in),
  .hreadyout_out(hreadyout_out),
  .hresp_out(hresp_out),
  .mem_out(mem_out),
  .busy_out(busy_out)
);

// file: verif/test_cpu_logic_branch_misc_exec.sv
// testbench: steps single instructions through the register bus
// assumes the byte memory model and a bound property checker
`timescale 1ns/1ps
module test_cpu_logic_branch_misc_exec;
  import exec_pkg::*;
  logic clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata, rv;
  logic hready, hresp, busy, cb;
  logic [7:0] mrd, ps, op;
  mem_req_t mem;
  int err_count = 0;
  int checks = 0;
  logic [7:0] ct [5][3] = '{'{8'h81, 8'h1F, 8'h1E}, '{8'h91, 8'h00, 8'h01},
    '{8'h80, 8'h1F, 8'h0F}, '{8'h90, 8'h00, 8'h10}, '{8'h00, 8'h1F, 8'h1F}};
  always #4 clk_in = ~clk_in;
  cpu_logic_branch_misc_exec DUT (.clk_in(clk_in), .rst_n_in(rst_n_in),
    .hsel_in(hsel), .haddr_in(haddr), .htrans_in(htrans),
    .hwrite_in(hwrite), .hsize_in(3'h2), .hwdata_in(hwdata),
    .hready_in(hready), .hrdata_out(hrdata), .hreadyout_out(hready),
    .hresp_out(hresp), .mem_out(mem), .mem_rdata_in(mrd), .busy_out(busy));
  exec_mem_model u_mem (.clk_in(clk_in), .mem_in(mem), .rdata_out(mrd));
  // ========================================
  // bus tasks
  task check(input string n, input logic [31:0] s, input logic [31:0] e);
    checks++;
    if (s !== e) begin
      err_count++;
      $display("unexpected %s expected %h seen %h", n, e, s);
    end
  endtask
  task ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_in);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    do @(posedge clk_in); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk_in); while (hready !== 1'b1);
    rv = hrdata;
  endtask
  task rchk(input string n, input logic [7:0] a, input logic [31:0] e);
    ahb(1'b0, a, 32'h0);
    check(n, rv, e);
  endtask
  // one instruction at pc; the wait is bounded, the watchdog backs it
  task step(input logic [15:0] pc);
    ahb(1'b1, OFF_PC, {16'h0, pc});
    ahb(1'b1, OFF_CTRL, 32'h1);
    @(posedge clk_in);
    for (int i = 0; i < 40 && busy !== 1'b0; i++) @(posedge clk_in);
  endtask
  task final_report;
    $display("checks %0d errors %0d", checks, err_count);
    if (err_count == 0 && checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk_in);
    err_count++;
    final_report();
  end
  // ========================================
  // scenarios
  initial begin
    repeat (10) @(posedge clk_in);
    rst_n_in <= 1'b1;
    rchk("unmapped", 8'h80, 32'h0);
    u_mem.mem[16'h0100] = 8'h3C;
    u_mem.mem[16'h0200] = 8'h67;
    u_mem.mem[16'h0210] = 8'h7D;
    ahb(1'b1, OFF_ACC, 32'h12F0);
    ahb(1'b1, OFF_EP, 32'h0100);
    ahb(1'b1, OFF_PS, 32'h3);
    step(16'h0200);
    rchk("and acc", OFF_ACC, 32'h1230);
    rchk("and ps", OFF_PS, 32'h1);
    rchk("and pc", OFF_PC, 32'h0201);
    ahb(1'b1, 8'h54, 32'h81);
    ahb(1'b1, OFF_PS, 32'h3);
    step(16'h0210);
    rchk("or acc", OFF_ACC, 32'h12B1);
    rchk("or ps", OFF_PS, 32'h9);
    u_mem.mem[16'h0301] = 8'hF0;
    for (int k = 0; k < 16; k++) begin
      ps = k[3] ? 8'h03 : 8'h0C;
      op = 8'hF8 + k[2:0];
      cb = op[2:1] == 2'h0 ? ps[0] : op[2:1] == 2'h1 ? ps[3] :
        op[2:1] == 2'h2 ? ps[2] : ps[1] ^ ps[3];
      u_mem.mem[16'h0300] = op;
      ahb(1'b1, OFF_PS, {24'h0, ps});
      step(16'h0300);
      rchk("branch pc", OFF_PC, (cb ^ !op[0]) ? 32'h02F2 : 32'h0302);
      rchk("branch ps", OFF_PS, {24'h0, ps});
    end
    u_mem.mem[16'h0311] = 8'h40;
    u_mem.mem[16'h0312] = 8'h05;
    u_mem.mem[16'h0040] = 8'h25;
    for (int k = 0; k < 16; k++) begin
      op = 8'hB0 + k[3:0];
      ps = 8'h25;
      cb = ps[op[2:0]] ^ !op[3];
      u_mem.mem[16'h0310] = op;
      ahb(1'b1, OFF_PS, 32'hB);
      step(16'h0310);
      rchk("bit pc", OFF_PC, cb ? 32'h0318 : 32'h0313);
      ahb(1'b0, OFF_PS, 32'h0);
      check("bit nvc", rv & 32'hB, 32'hB);
      check("bit z", {31'h0, rv[F_Z]}, {31'h0, ~ps[op[2:0]]});
    end
    u_mem.mem[16'h0500] = 8'h31;
    u_mem.mem[16'h0501] = 8'h05;
    u_mem.mem[16'h0502] = 8'h80;
    u_mem.mem[16'h0580] = 8'h20;
    ahb(1'b1, OFF_SP, 32'h0400);
    ahb(1'b1, OFF_PS, 32'h5);
    step(16'h0500);
    rchk("call pc", OFF_PC, 32'h0580);
    rchk("call sp", OFF_SP, 32'h03FE);
    check("ret hi", u_mem.mem[16'h03FE], 32'h05);
    check("ret lo", u_mem.mem[16'h03FF], 32'h03);
    step(16'h0580);
    rchk("ret pc", OFF_PC, 32'h0503);
    rchk("ret sp", OFF_SP, 32'h0400);
    rchk("ret ps", OFF_PS, 32'h5);
    u_mem.mem[16'h0600] = 8'h41;
    u_mem.mem[16'h0601] = 8'h50;
    ahb(1'b1, OFF_IX, 32'hBEEF);
    step(16'h0600);
    check("push hi", u_mem.mem[16'h03FE], 32'hBE);
    check("push lo", u_mem.mem[16'h03FF], 32'hEF);
    step(16'h0601);
    rchk("pop acc", OFF_ACC, 32'hBEEF);
    rchk("pop sp", OFF_SP, 32'h0400);
    for (int k = 0; k < 5; k++) begin
      u_mem.mem[16'h0700] = ct[k][0];
      ahb(1'b1, OFF_PS, {24'h0, ct[k][1]});
      step(16'h0700);
      rchk("ctl ps", OFF_PS, {24'h0, ct[k][2]});
      rchk("ctl pc", OFF_PC, 32'h0701);
    end
    u_mem.mem[16'h0710] = 8'h01;
    step(16'h0710);
    rchk("rsvd status", OFF_STATUS, 32'h2);
    rchk("rsvd pc", OFF_PC, 32'h0711);
    u_mem.mem[16'h0800] = 8'hD1;
    u_mem.mem[16'h0810] = 8'hE0;
    u_mem.mem[16'h0820] = 8'hF4;
    ahb(1'b1, OFF_SP, 32'h0400);
    ahb(1'b1, OFF_PS, 32'h5);
    step(16'h0800);
    rchk("sp step", OFF_SP, 32'h03FF);
    rchk("sp ps", OFF_PS, 32'h5);
    ahb(1'b1, OFF_ACC, 32'h0820);
    step(16'h0810);
    rchk("jmp pc", OFF_PC, 32'h0820);
    ahb(1'b1, OFF_ACC, 32'h0900);
    step(16'h0820);
    rchk("xch pc", OFF_PC, 32'h0900);
    rchk("xch acc", OFF_ACC, 32'h0821);
    // compare: 30 minus 40 borrows, so N and C set, V clear
    u_mem.mem[16'h0900] = 8'h96;
    u_mem.mem[16'h0901] = 8'h02;
    u_mem.mem[16'h0902] = 8'h40;
    u_mem.mem[16'h0102] = 8'h30;
    ahb(1'b1, OFF_IX, 32'h0100);
    ahb(1'b1, OFF_PS, 32'h0);
    step(16'h0900);
    rchk("cmp ps", OFF_PS, 32'h9);
    rchk("cmp acc", OFF_ACC, 32'h0821);
    rchk("cmp pc", OFF_PC, 32'h0903);
    u_mem.mem[16'h0950] = 8'h30;
    u_mem.mem[16'h0400] = 8'h0A;
    u_mem.mem[16'h0401] = 8'h00;
    u_mem.mem[16'h0402] = 8'h28;
    u_mem.mem[16'h0403] = 8'h0F;
    ahb(1'b1, OFF_SP, 32'h0400);
    step(16'h0950);
    rchk("interrupt_return pc", OFF_PC, 32'h0A00);
    rchk("interrupt_return ps", OFF_PS, 32'h280F);
    rchk("interrupt_return sp", OFF_SP, 32'h0404);
    u_mem.mem[16'h0960] = 8'h72;
    ahb(1'b1, OFF_ACC, 32'h0010);
    ahb(1'b1, OFF_TMP, 32'h0003);
    step(16'h0960);
    rchk("or t acc", OFF_ACC, 32'h0013);
    rchk("or t ps", OFF_PS, 32'h2801);
    final_report();
  end
endmodule // test_cpu_logic_branch_misc_exec
